// file: hw/dpsm_pkg.sv
// Shared constants and types for the loop status and mode pin block.
package dpsm_pkg;

  // Clock and reset-hold timing.
  localparam int CLK_PERIOD_NS = 40;
  localparam int RESET_HOLD_NS = 3000000;
  localparam int RESET_HOLD_CYCLES =
    (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CNT_W = 17;

  // Register bus geometry.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets.
  localparam logic [7:0] STATUS_OFS = 8'h00;
  localparam logic [7:0] EVENT_OFS = 8'h04;
  localparam logic [7:0] MASK_OFS = 8'h08;

  // Event and mask bit positions.
  localparam int EV_LOCK_CHG = 0;
  localparam int EV_HOLD_ENTRY = 1;
  localparam int EV_BAD0 = 2;
  localparam int EV_W = 5;
  localparam logic [4:0] MASK_RESET = 5'h00;

  // Live status field positions.
  localparam int ST_LOCK = 0;
  localparam int ST_HOLD = 1;
  localparam int ST_BAD0 = 2;
  localparam int ST_MODE0 = 5;
  localparam int ST_USE0 = 7;
  localparam int ST_HITLESS = 9;
  localparam int ST_READY = 10;

  // Number of monitored input references.
  localparam int NUM_REFS = 3;
  localparam int OFS_W = 16;

  // Out-of-range limits per target use code, in offset units.
  localparam logic [15:0] OOR_LIMIT_USE0 = 16'h0010;
  localparam logic [15:0] OOR_LIMIT_USE1 = 16'h0020;
  localparam logic [15:0] OOR_LIMIT_USE2 = 16'h0040;

  // Operating mode as decoded from the two mode pins.
  typedef enum logic [1:0] {
    DPSM_MODE_NORMAL,
    DPSM_MODE_HOLDOVER,
    DPSM_MODE_FREERUN,
    DPSM_MODE_AUTO
  } dpsm_mode_t;

  // Effective loop state seen by the status logic.
  typedef enum logic [1:0] {
    DPSM_ST_NORMAL,
    DPSM_ST_HOLDOVER,
    DPSM_ST_FREERUN
  } dpsm_state_t;

  // Control pins after synchronisation.
  typedef struct packed {
    logic [1:0] op_mode_code;
    logic [1:0] target_use_code;
    logic hitless_return_select;
  } dpsm_pins_t;

  // Status outputs before the tri-state stage.
  typedef struct packed {
    logic freq_lock;
    logic holdover;
    logic [2:0] bad;
  } dpsm_status_t;

endpackage

// file: hw/dpsm_ref_check.sv
// Failure detector for one input reference.
`timescale 1ns/1ps

module dpsm_ref_check (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset,
  // Selected target use code, already synchronised.
  input wire logic [1:0] target_use_code,
  // Frequency offset measurement from the reference monitor.
  input wire logic offset_valid,
  input wire logic signed [15:0] offset,
  // Abrupt phase or frequency change seen by the monitor.
  input wire logic abrupt_change,
  // Registered failure flag.
  output logic bad_flag
);

  // Magnitude of the offset; the most negative value comes out as 16'h8000 unchanged.
  wire logic [15:0] offset_mag;
  // Limit picked by the target use code.
  wire logic [15:0] limit;
  // Offset beyond the limit on this measurement.
  wire logic over_range;
  // Last out-of-range verdict, held between measurements.
  logic out_of_range;
  // Flag value for the next edge.
  wire logic next_bad_flag;

  assign offset_mag = offset[15] ? 16'(-offset) : 16'(offset);

  // Use codes two and three share the widest window.
  assign limit = (target_use_code == 2'h0) ? dpsm_pkg::OOR_LIMIT_USE0 :
                 (target_use_code == 2'h1) ? dpsm_pkg::OOR_LIMIT_USE1 :
                 dpsm_pkg::OOR_LIMIT_USE2;

  assign over_range = (offset_mag > limit) || (offset == 16'sh8000);

  assign next_bad_flag = out_of_range || abrupt_change;

  // The verdict only moves on a new measurement; between them the flag moves only with abrupt_change.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      out_of_range <= 1'b0;
    end else if (offset_valid) begin
      out_of_range <= over_range;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      bad_flag <= 1'b0;
    end else begin
      bad_flag <= next_bad_flag;
    end
  end

endmodule

// file: hw/dpsm_top.sv
// Loop status outputs, mode pin decode and reference failure flags.
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/1ps

module dpsm_top #(
  parameter int RESET_HOLD_CYCLES = dpsm_pkg::RESET_HOLD_CYCLES
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset,
  // Control pins from the board controller.
  input wire logic op_mode_code_bit0,
  input wire logic op_mode_code_bit1,
  input wire logic target_use_code_bit0,
  input wire logic target_use_code_bit1,
  input wire logic hitless_return_select,
  // Loop core status, same clock.
  input wire logic loop_locked,
  input wire logic loop_lost_reference,
  input wire logic [1:0] active_ref,
  // Reference monitor measurements, same clock.
  input wire logic [2:0] ref_offset_valid,
  input wire logic [47:0] ref_offset,
  input wire logic [2:0] ref_abrupt_change,
  // Status pins, with an active-low drive enable per pin.
  output logic freq_lock_flag,
  output logic holdover_flag,
  output logic input0_bad_flag,
  output logic input1_bad_flag,
  output logic input2_bad_flag,
  output logic [4:0] status_oe_n,
  // Decoded mode and corrector commands to the loop core.
  output dpsm_pkg::dpsm_mode_t op_mode,
  output logic phase_offset_corrector_keep,
  output logic phase_offset_corrector_remeasure,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  // Interrupt, high while an unmasked event is pending.
  output logic irq
);

  // Raw control pins gathered into one vector.
  wire logic [4:0] pins_raw;
  // Three synchroniser stages per pin.
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic [4:0] sync3;
  // Accepted pin values once two stages agree.
  logic [4:0] pins_stable;
  wire dpsm_pkg::dpsm_pins_t pins;

  // Reset-hold counter and ready flag.
  logic [16:0] hold_cnt;
  logic ready;
  wire logic hold_done;

  // Effective loop state, its previous value and the previous reference.
  wire dpsm_pkg::dpsm_state_t next_state;
  dpsm_pkg::dpsm_state_t loop_state;
  logic [1:0] prev_ref;
  wire logic returning;

  // Status values before the tri-state stage.
  wire dpsm_pkg::dpsm_status_t next_status;
  dpsm_pkg::dpsm_status_t status;
  wire logic [2:0] bad_raw;

  // Event, mask and decode signals of the register port.
  logic [4:0] event_flags;
  logic [4:0] event_mask;
  wire logic [4:0] event_set;
  wire logic [4:0] event_clear;
  wire logic hit_status;
  wire logic hit_event;
  wire logic hit_mask;
  wire logic [31:0] status_word;
  wire logic [31:0] next_rdata;

  assign pins_raw = {op_mode_code_bit1, op_mode_code_bit0,
                     target_use_code_bit1, target_use_code_bit0,
                     hitless_return_select};

  // Pins arrive from another domain; each passes three flip-flops.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sync1 <= 5'h00;
      sync2 <= 5'h00;
      sync3 <= 5'h00;
    end else begin
      sync1 <= pins_raw;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // A pin change counts once stages two and three agree.
  generate
    for (genvar i = 0; i < 5; i++) begin : g_pin
      always_ff @(posedge core_clk) begin
        if (reset) begin
          pins_stable[i] <= 1'b0;
        end else if (sync2[i] == sync3[i]) begin
          pins_stable[i] <= sync3[i];
        end
      end
    end
  endgenerate

  assign pins = dpsm_pkg::dpsm_pins_t'(pins_stable);

  assign op_mode = dpsm_pkg::dpsm_mode_t'(pins.op_mode_code);

  // Hold window after reset; a long count, shortened by the parameter.
  assign hold_done = (hold_cnt >= 17'(RESET_HOLD_CYCLES - 1));

  always_ff @(posedge core_clk) begin
    if (reset) begin
      hold_cnt <= 17'h00000;
      ready <= 1'b0;
    end else if (!ready) begin
      hold_cnt <= hold_cnt + 17'h00001;
      ready <= hold_done;
    end
  end

  // Forced modes win; normal and automatic fall back on the core.
  assign next_state =
    (op_mode == dpsm_pkg::DPSM_MODE_FREERUN) ? dpsm_pkg::DPSM_ST_FREERUN :
    (op_mode == dpsm_pkg::DPSM_MODE_HOLDOVER) ? dpsm_pkg::DPSM_ST_HOLDOVER :
    loop_lost_reference ? dpsm_pkg::DPSM_ST_HOLDOVER :
    dpsm_pkg::DPSM_ST_NORMAL;

  // Remember state and reference so a return can be recognised.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      loop_state <= dpsm_pkg::DPSM_ST_FREERUN;
      prev_ref <= 2'h0;
    end else if (ready) begin
      loop_state <= next_state;
      prev_ref <= active_ref;
    end
  end

  // A return means leaving holdover or freerun on the same reference.
  assign returning = ready &&
    (loop_state != dpsm_pkg::DPSM_ST_NORMAL) &&
    (next_state == dpsm_pkg::DPSM_ST_NORMAL) &&
    (active_ref == prev_ref);

  // Corrector commands are one-cycle pulses on the return edge.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      phase_offset_corrector_keep <= 1'b0;
      phase_offset_corrector_remeasure <= 1'b0;
    end else begin
      phase_offset_corrector_keep <=
        returning && !pins.hitless_return_select;
      phase_offset_corrector_remeasure <=
        returning && pins.hitless_return_select;
    end
  end

  // One failure detector per reference.
  generate
    for (genvar r = 0; r < dpsm_pkg::NUM_REFS; r++) begin : g_ref
      dpsm_ref_check u_check (
        .core_clk(core_clk),
        .reset(reset),
        .target_use_code(pins.target_use_code),
        .offset_valid(ref_offset_valid[r]),
        .offset(ref_offset[16*r +: 16]),
        .abrupt_change(ref_abrupt_change[r]),
        .bad_flag(bad_raw[r])
      );
    end
  endgenerate

  assign next_status.freq_lock = ready && loop_locked &&
    (next_state == dpsm_pkg::DPSM_ST_NORMAL);
  assign next_status.holdover = ready &&
    (next_state == dpsm_pkg::DPSM_ST_HOLDOVER);
  assign next_status.bad = ready ? bad_raw : 3'h0;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      status <= '0;
    end else begin
      status <= next_status;
    end
  end

  assign freq_lock_flag = status.freq_lock;
  assign holdover_flag = status.holdover;
  assign input0_bad_flag = status.bad[0];
  assign input1_bad_flag = status.bad[1];
  assign input2_bad_flag = status.bad[2];

  always_ff @(posedge core_clk) begin
    if (reset) begin
      status_oe_n <= 5'h1F;
    end else begin
      status_oe_n <= ready ? 5'h00 : 5'h1F;
    end
  end

  // Events are status edges (any lock change, rising holdover and bad), so they need no extra state.
  assign event_set[dpsm_pkg::EV_LOCK_CHG] =
    next_status.freq_lock != status.freq_lock;
  assign event_set[dpsm_pkg::EV_HOLD_ENTRY] =
    next_status.holdover && !status.holdover;
  assign event_set[dpsm_pkg::EV_BAD0 +: 3] = next_status.bad & ~status.bad;

  // Address decode for the three words of the map.
  assign hit_status = (reg_addr == dpsm_pkg::STATUS_OFS);
  assign hit_event = (reg_addr == dpsm_pkg::EVENT_OFS);
  assign hit_mask = (reg_addr == dpsm_pkg::MASK_OFS);
  assign event_clear = (reg_write && hit_event) ? reg_wdata[4:0] : 5'h00;

  // Sticky events; a new event in the clearing cycle survives.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      event_flags <= 5'h00;
    end else begin
      event_flags <= (event_flags & ~event_clear) | event_set;
    end
  end

  // The mask gates which events reach the interrupt line.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      event_mask <= dpsm_pkg::MASK_RESET;
    end else if (reg_write && hit_mask) begin
      event_mask <= reg_wdata[4:0];
    end
  end

  assign irq = |(event_flags & event_mask);

  // Live view of the block for software.
  assign status_word = {21'h000000, ready, pins.hitless_return_select,
                        pins.target_use_code, pins.op_mode_code,
                        status.bad, status.holdover, status.freq_lock};

  // Unmapped addresses read as zero.
  assign next_rdata =
    !reg_read ? 32'h00000000 :
    hit_status ? status_word :
    hit_event ? {27'h0000000, event_flags} :
    hit_mask ? {27'h0000000, event_mask} :
    32'h00000000;

  // Read data stand in the cycle after the read strobe only.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      reg_rdata <= 32'h00000000;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule

// file: bench/dpsm_props.sv
// Concurrent checks on the status and mode pin block.
`timescale 1ns/1ps
module dpsm_props #(
  parameter int RESET_HOLD_CYCLES = 20
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset,
  // Pins and core inputs.
  input wire logic op_mode_code_bit0,
  input wire logic op_mode_code_bit1,
  input wire logic loop_locked,
  input wire logic [2:0] ref_abrupt_change,
  // Outputs watched.
  input wire logic freq_lock_flag,
  input wire logic holdover_flag,
  input wire logic input0_bad_flag,
  input wire logic [4:0] status_oe_n,
  input wire dpsm_pkg::dpsm_mode_t op_mode,
  input wire logic phase_offset_corrector_keep,
  input wire logic phase_offset_corrector_remeasure
);
  // Edges since reset release; saturates so it never wraps.
  int cnt;
  wire [1:0] pin_code;
  wire any_pulse;
  assign pin_code = {op_mode_code_bit1, op_mode_code_bit0};
  assign any_pulse = phase_offset_corrector_keep |
    phase_offset_corrector_remeasure;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cnt <= 0;
    end else if (cnt < 1000000) begin
      cnt <= cnt + 1;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  property p_oe_early;
    status_oe_n != 5'h1F |-> cnt >= RESET_HOLD_CYCLES;
  endproperty
  a_oe_early: assert property (p_oe_early)
    else $error("pins driven before hold time");
  property p_oe_late;
    cnt == RESET_HOLD_CYCLES + 3 |-> status_oe_n == 5'h00;
  endproperty
  a_oe_late: assert property (p_oe_late)
    else $error("pins still undriven after hold time");
  property p_oe_eq;
    status_oe_n == 5'h00 || status_oe_n == 5'h1F;
  endproperty
  a_oe_eq: assert property (p_oe_eq)
    else $error("drive enables disagree");
  property p_hiz;
    status_oe_n == 5'h1F |->
      !(freq_lock_flag | holdover_flag | input0_bad_flag);
  endproperty
  a_hiz: assert property (p_hiz)
    else $error("flag high while undriven");
  property p_bad0;
    status_oe_n == 5'h00 && ref_abrupt_change[0] |=> input0_bad_flag;
  endproperty
  a_bad0: assert property (p_bad0)
    else $error("abrupt change not flagged");
  property p_mode;
    $stable(pin_code) [*6] |-> op_mode == dpsm_pkg::dpsm_mode_t'(pin_code);
  endproperty
  a_mode: assert property (p_mode)
    else $error("mode decode wrong");
  property p_pulse;
    any_pulse |=> !any_pulse;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("corrector command longer than one cycle");
  property p_excl;
    !(phase_offset_corrector_keep && phase_offset_corrector_remeasure);
  endproperty
  a_excl: assert property (p_excl)
    else $error("keep and remeasure together");
  property p_lock;
    $rose(freq_lock_flag) |-> $past(loop_locked) || $past(loop_locked, 2);
  endproperty
  a_lock: assert property (p_lock)
    else $error("lock flag rose without loop lock");
endmodule

bind dpsm_top dpsm_props #(.RESET_HOLD_CYCLES(RESET_HOLD_CYCLES)) i_props (
  .core_clk(core_clk),
  .reset(reset),
  .op_mode_code_bit0(op_mode_code_bit0),
  .op_mode_code_bit1(op_mode_code_bit1),
  .loop_locked(loop_locked),
  .ref_abrupt_change(ref_abrupt_change),
  .freq_lock_flag(freq_lock_flag),
  .holdover_flag(holdover_flag),
  .input0_bad_flag(input0_bad_flag),
  .status_oe_n(status_oe_n),
  .op_mode(op_mode),
  .phase_offset_corrector_keep(phase_offset_corrector_keep),
  .phase_offset_corrector_remeasure(phase_offset_corrector_remeasure)
);

// file: bench/dpsm_ctrl_model.sv
// Board controller model driving the mode, use and hitless pins.
`timescale 1ns/1ps
module dpsm_ctrl_model (
  // Clock and bench commands.
  input wire logic core_clk,
  input wire logic [1:0] mode_cmd,
  input wire logic [1:0] use_cmd,
  input wire logic hit_cmd,
  // Pins toward the block.
  output logic op_mode_code_bit0 = 1'b0,
  output logic op_mode_code_bit1 = 1'b0,
  output logic target_use_code_bit0 = 1'b0,
  output logic target_use_code_bit1 = 1'b0,
  output logic hitless_return_select = 1'b0
);
  // mode pair, use pair and hitless pin driven
  // Both bits of a pair move on one edge, so no half code is shown.
  always @(posedge core_clk) begin
    {op_mode_code_bit1, op_mode_code_bit0} <= mode_cmd;
    {target_use_code_bit1, target_use_code_bit0} <= use_cmd;
    hitless_return_select <= hit_cmd;
  end
endmodule

// file: bench/testbench.sv
// Self-checking bench for the status and mode pin block.
`timescale 1ns/1ps
`define CHK(g, e) check_val(32'(g), 32'(e))
module testbench;
  localparam int HOLD = 20;
  localparam logic [1:0] EXP [4] = '{2'h2, 2'h1, 2'h0, 2'h2};
  // Clock, reset and controller commands.
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [1:0] mode_cmd = 2'h0;
  logic [1:0] use_cmd = 2'h0;
  logic hit_cmd = 1'b0;
  wire m0, m1, u0, u1, hit;
  // Loop core, monitor and register inputs.
  logic locked = 1'b0;
  logic lost = 1'b0;
  logic [2:0] ovalid = 3'h0;
  logic [47:0] offs = 48'h0;
  logic [2:0] abrupt = 3'h0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  // Outputs.
  wire lock_f, hold_f, bad0, bad1, bad2, keep, rem, irq;
  wire [4:0] oe_n;
  wire [31:0] rdata;
  dpsm_pkg::dpsm_mode_t mode;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  always #20 core_clk = ~core_clk;
  dpsm_ctrl_model i_ctrl (.core_clk(core_clk), .mode_cmd(mode_cmd),
    .use_cmd(use_cmd), .hit_cmd(hit_cmd), .op_mode_code_bit0(m0),
    .op_mode_code_bit1(m1), .target_use_code_bit0(u0),
    .target_use_code_bit1(u1), .hitless_return_select(hit));
  dpsm_top #(.RESET_HOLD_CYCLES(HOLD)) i_dut (.core_clk(core_clk),
    .reset(reset), .op_mode_code_bit0(m0), .op_mode_code_bit1(m1),
    .target_use_code_bit0(u0), .target_use_code_bit1(u1),
    .hitless_return_select(hit), .loop_locked(locked),
    .loop_lost_reference(lost), .active_ref(2'h0),
    .ref_offset_valid(ovalid), .ref_offset(offs),
    .ref_abrupt_change(abrupt), .freq_lock_flag(lock_f),
    .holdover_flag(hold_f), .input0_bad_flag(bad0),
    .input1_bad_flag(bad1), .input2_bad_flag(bad2), .status_oe_n(oe_n),
    .op_mode(mode), .phase_offset_corrector_keep(keep),
    .phase_offset_corrector_remeasure(rem), .reg_addr(addr),
    .reg_wdata(wdata), .reg_write(wr), .reg_read(rd), .reg_rdata(rdata),
    .irq(irq));
  task automatic check_val(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // A hang counts as a mismatch and closes the run.
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors++;
      stop_test();
    end
  end
  // Values are read at the edge, before that edge's updates land.
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    rd <= 1'b0;
    @(posedge core_clk);
    `CHK(rdata, e);
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  // Pins need the model edge plus synchronisers before they count.
  task automatic set_pins(input logic [1:0] m, input logic [1:0] u,
    input logic h);
    @(posedge core_clk);
    mode_cmd <= m;
    use_cmd <= u;
    hit_cmd <= h;
    repeat (9) @(posedge core_clk);
  endtask
  task automatic t_hold();
    repeat (HOLD - 2) @(posedge core_clk);
    `CHK(oe_n, 5'h1F);
    `CHK({lock_f, hold_f, bad0, bad1, bad2}, 5'h00);
    repeat (6) @(posedge core_clk);
    `CHK(oe_n, 5'h00);
    $display("test hold done");
  endtask
  task automatic t_status();
    @(posedge core_clk);
    locked <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      set_pins(2'(m), 2'h0, 1'b0);
      `CHK(mode, m);
      `CHK({lock_f, hold_f}, EXP[m]);
    end
    $display("test status done");
  endtask
  task automatic t_return(input logic h);
    logic [3:0] k;
    logic [3:0] r;
    set_pins(2'h0, 2'h0, h);
    @(posedge core_clk);
    lost <= 1'b1;
    repeat (4) @(posedge core_clk);
    `CHK({lock_f, hold_f}, 2'h1);
    lost <= 1'b0;
    k = 4'h0;
    r = 4'h0;
    repeat (6) begin
      @(posedge core_clk);
      k = k + {3'h0, keep};
      r = r + {3'h0, rem};
    end
    `CHK({k, r}, h ? 8'h01 : 8'h10);
    $display("test return done");
  endtask
  // Ref 0 gets +v, ref 2 gets -v and ref 1 stays in range.
  task automatic offer(input logic [15:0] v, input logic [2:0] e);
    @(posedge core_clk);
    offs <= {16'h0000 - v, 16'h0000, v};
    ovalid <= 3'h7;
    @(posedge core_clk);
    ovalid <= 3'h0;
    repeat (3) @(posedge core_clk);
    `CHK({bad2, bad1, bad0}, e);
  endtask
  task automatic t_bad();
    logic [15:0] lim;
    for (int u = 0; u < 4; u++) begin
      set_pins(2'h0, 2'(u), 1'b0);
      lim = (u == 0) ? dpsm_pkg::OOR_LIMIT_USE0 : (u == 1) ?
        dpsm_pkg::OOR_LIMIT_USE1 : dpsm_pkg::OOR_LIMIT_USE2;
      offer(lim, 3'h0);
      offer(lim + 16'h0001, 3'h5);
      offer(16'h0000, 3'h0);
    end
    offer(16'h8000, 3'h5);
    offer(16'h0000, 3'h0);
    @(posedge core_clk);
    abrupt <= 3'h2;
    repeat (3) @(posedge core_clk);
    `CHK({bad2, bad1, bad0}, 3'h2);
    abrupt <= 3'h0;
    repeat (3) @(posedge core_clk);
    `CHK({bad2, bad1, bad0}, 3'h0);
    $display("test bad done");
  endtask
  // Bad-rising events from the previous test are still pending here.
  task automatic t_regs();
    reg_rd(dpsm_pkg::STATUS_OFS, 32'h581);
    reg_rd(dpsm_pkg::MASK_OFS, 32'h0);
    `CHK(irq, 1'b0);
    reg_wr(dpsm_pkg::MASK_OFS, 32'h1C);
    reg_rd(dpsm_pkg::MASK_OFS, 32'h1C);
    `CHK(irq, 1'b1);
    reg_wr(dpsm_pkg::EVENT_OFS, 32'h1F);
    reg_rd(dpsm_pkg::EVENT_OFS, 32'h0);
    reg_rd(8'hF0, 32'h0);
    `CHK(irq, 1'b0);
    $display("test regs done");
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    t_hold();
    t_status();
    t_return(1'b0);
    t_return(1'b1);
    t_bad();
    t_regs();
    stop_test();
  end
endmodule
